// ===== rtl/can_command_status_logic.sv
// What this block does
// R1: Sleep only with no interrupt, no bus activity
// R2: Refused sleep request raises wake-up interrupt
// R3: Clock output runs fifteen bit times, then low
// R4: Wake on request clear, bus activity, interrupt low
// R5: After bus wake, wait eleven recessive bits
// R6: Sleep ignored in reset, until bus free
// R7: Clear overrun command clears overrun flag
// R8: No new overrun interrupt while flag set
// R9: Clear overrun and release together both work
// R10: Release frees message; next one re-interrupts
// R11: Empty after release clears full flag
// R12: Abort cancels pending, not running, transmission
// R13: Transmit request sticks until aborted; code also drops it when its frame ends, even failed
// R14: Host checks completion after buffer freed
// R15: Status read-only; top bit shows bus-off
// R16: Warning flag when a counter reaches limit
// R17: Activity flags follow transmit and receive
// R18: Completion flag shows last transmission succeeded
// R19: Buffer free flag; locked while pending/sending
// R20: Overrun flag set on lost message, sticky
// R21: Full flag while any message stored
// R22: Warning limit is ninety-six
// R23: Transmit request forces completion flag low
// R24: Buffer writes while locked are dropped
// R25: Host spaces command writes one cycle apart
// R26: Command bits act as one-cycle pulses
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module can_command_status_logic #(
  parameter int MSG_COUNT_W = 4 // Width of stored-message count
) (
  input wire logic core_clk, // Internal clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [ccsl_pkg::ADDR_W-1:0] regAddr, // Register address
  input wire logic [ccsl_pkg::DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [ccsl_pkg::DATA_W-1:0] regRdata, // Read data, next cycle
  input wire logic resetMode, // Controller in reset mode
  input wire logic busOff, // Frame engine is bus-off
  input wire logic [7:0] txErrCount, // Transmit error counter
  input wire logic [7:0] rxErrCount, // Receive error counter
  input wire logic busActive, // Frame seen on the bus
  input wire logic bitTick, // One pulse per bit time
  input wire logic recessiveBit, // Sampled bit is recessive
  input wire logic irqPending, // Some interrupt is pending
  input wire logic interruptLineLow, // Interrupt pin driven low
  input wire logic rxIrqEnable, // Receive interrupt enable
  input wire logic txStarted, // Engine began sending frame
  input wire logic txDone, // Frame sent successfully
  input wire logic txEnded, // Frame ended, ok or failed
  input wire logic rxActive, // Engine is receiving
  input wire logic msgStored, // Message written into fifo
  input wire logic msgLost, // Message dropped, fifo full
  input wire logic txBufWrite, // Host writes transmit buffer
  output logic txBufWriteAccept, // Buffer write allowed
  output logic txGo, // Pending frame to send
  output logic rxRelease, // Release pulse to fifo
  output logic rxEnable, // Reception allowed
  output logic sleeping, // Sleep mode, oscillator off
  output logic clockOutEnable, // Clock output may toggle
  output logic wakeIrq, // Wake-up interrupt pulse
  output logic overrunIrq, // Overrun interrupt pulse
  output logic errorIrq, // Error state change pulse
  output logic rxIrq // Receive interrupt pulse
);
  import ccsl_pkg::*;

  logic [7:0] cmd;
  logic cmdWrite;
  logic overrunFlag;
  logic txDoneFlag;
  logic errWarn;
  logic errWarnLast;
  logic busOffLast;
  logic [MSG_COUNT_W-1:0] msgCount;
  logic [MSG_COUNT_W-1:0] next_msgCount;
  logic [3:0] recessiveRun;
  logic [3:0] clkHold;
  logic busFreeSeen;
  logic sleepArmed;
  logic rxBlocked;
  logic resetModeLast;
  logic [7:0] statusWord;
  ccsl_sleep_t sleepState;
  ccsl_tx_t txState;
  // Decoded sleep and release conditions, shared below
  logic wakeCause;
  logic sleepAccept;
  logic sleepRefused;
  logic releaseHit;

  // Commands exist only for the write cycle, never stored
  assign cmdWrite = regWr && (regAddr == CMD_OFFSET); // R26
  assign cmd = cmdWrite ? regWdata : 8'h00; // R26

  // Any of the three wake conditions, for both sleep states.
  // A command write with the sleep bit low counts as a wake.
  assign wakeCause = busActive || interruptLineLow ||
                     (cmdWrite && !regWdata[CMD_SLEEP]); // R4

  // Sleep request granted only when armed and quiet
  assign sleepAccept = cmd[CMD_SLEEP] && sleepArmed && !resetMode &&
                       !irqPending && !busActive; // R1 R6

  // Refusal outside reset mode still tells the host via wake-up
  assign sleepRefused = cmd[CMD_SLEEP] && !resetMode &&
                        (irqPending || busActive); // R2

  // Release only counts when a message is actually held.
  // An empty fifo ignores the command, so no underflow.
  assign releaseHit = cmd[CMD_RELEASE] && (msgCount != '0); // R10

  // Bus-free detector: eleven recessive bits in a row.
  // Bus activity or reset mode restarts the run, so a bus
  // free seen long ago cannot re-arm sleep or reception.
  // The run saturates at eleven rather than wrapping.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      recessiveRun <= 4'h0;
    else if (busActive || resetMode)
      recessiveRun <= 4'h0; // R5 R6
    else if (bitTick)
    begin
      if (!recessiveBit)
        recessiveRun <= 4'h0;
      else if (recessiveRun != 4'(BUS_FREE_BITS))
        recessiveRun <= recessiveRun + 4'h1;
    end
  end
  assign busFreeSeen = (recessiveRun == 4'(BUS_FREE_BITS)); // R5

  // Sleep is re-armed only by bus-free after reset mode.
  // Without this a request right after reset mode could
  // put the part to sleep before it joined the bus.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sleepArmed <= 1'b0;
      resetModeLast <= 1'b1;
    end
    else
    begin
      resetModeLast <= resetMode;
      if (resetMode)
        sleepArmed <= 1'b0; // R6
      else if (busFreeSeen)
        sleepArmed <= 1'b1; // R6
    end
  end

  // Sleep state machine; oscillator stops after drain
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sleepState <= CCSL_AWAKE;
      clkHold <= 4'h0;
      rxBlocked <= 1'b0;
    end
    else
    begin
      if (busFreeSeen)
        rxBlocked <= 1'b0; // R5
      case (sleepState)
        CCSL_AWAKE:
        begin
          if (sleepAccept) // R1
          begin
            sleepState <= CCSL_DRAIN;
            clkHold <= 4'h0;
          end
        end
        CCSL_DRAIN:
        begin
          // Host clocked from us needs time to reach standby,
          // so the clock output keeps running through the drain
          if (wakeCause) // R4
          begin
            sleepState <= CCSL_AWAKE;
            rxBlocked <= busActive; // R5
          end
          else if (bitTick)
          begin
            if (clkHold == 4'(CLOCK_OUTPUT_PIN_HOLD_BITS - 1))
              sleepState <= CCSL_ASLEEP; // R3
            else
              clkHold <= clkHold + 4'h1; // R3
          end
        end
        CCSL_ASLEEP:
        begin
          // Oscillator restarts on any wake cause
          if (wakeCause) // R4
          begin
            sleepState <= CCSL_AWAKE;
            rxBlocked <= busActive; // R5
          end
        end
        default:
          sleepState <= CCSL_AWAKE;
      endcase
    end
  end

  // Wake-up interrupt on leaving sleep or on a refused request.
  // A wake during the drain also interrupts, since the host
  // may already be heading for its own standby.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wakeIrq <= 1'b0;
    else
      wakeIrq <= ((sleepState != CCSL_AWAKE) && wakeCause) // R4
                 || ((sleepState == CCSL_AWAKE) && sleepRefused); // R2
  end

  assign sleeping = (sleepState == CCSL_ASLEEP);
  assign clockOutEnable = (sleepState != CCSL_ASLEEP); // R3
  assign rxEnable = !rxBlocked && !resetMode; // R5

  // Transmit request lifecycle; abort, reset mode or its frame ending, ok or failed, clears it.
  // A request while busy is dropped: the buffer is locked
  // then, so the host has nothing new to send.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      txState <= CCSL_TX_IDLE;
    else if (resetMode)
      txState <= CCSL_TX_IDLE;
    else
    begin
      case (txState)
        CCSL_TX_IDLE:
          if (cmd[CMD_TX_REQ])
            txState <= CCSL_TX_PEND; // R13
        CCSL_TX_PEND:
          if (txStarted)
            txState <= CCSL_TX_BUSY;
          else if (cmd[CMD_ABORT])
            txState <= CCSL_TX_IDLE; // R12
        CCSL_TX_BUSY:
          // Abort cannot stop a frame already on the wire
          if (txEnded || txDone)
            txState <= CCSL_TX_IDLE; // R12
        default:
          txState <= CCSL_TX_IDLE;
      endcase
    end
  end
  assign txGo = (txState == CCSL_TX_PEND);
  assign txBufWriteAccept = txBufWrite && (txState == CCSL_TX_IDLE); // R24

  // Completion flag; a new request wins over a done.
  // Reads one out of reset, as no request is outstanding.
  // An aborted request leaves it low, telling host it failed.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      txDoneFlag <= 1'b1;
    else if (cmd[CMD_TX_REQ] && txState == CCSL_TX_IDLE)
      txDoneFlag <= 1'b0; // R23
    else if (txDone && txState == CCSL_TX_BUSY)
      txDoneFlag <= 1'b1; // R18
  end

  // Overrun flag; set wins over a clear in the same cycle.
  // The interrupt fires only on the rising flag, so a
  // burst of lost messages gives the host one event.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overrunFlag <= 1'b0;
      overrunIrq <= 1'b0;
    end
    else
    begin
      overrunIrq <= msgLost && !overrunFlag; // R8
      if (msgLost)
        overrunFlag <= 1'b1; // R20
      else if (cmd[CMD_CLR_OVR])
        overrunFlag <= 1'b0; // R7 R9
    end
  end

  // Stored message count, release and store may coincide
  always_comb
  begin
    next_msgCount = msgCount;
    if (msgStored && !(&msgCount))
      next_msgCount = next_msgCount + 1'b1;
    if (releaseHit)
      next_msgCount = next_msgCount - 1'b1; // R10 R9
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      msgCount <= '0;
      rxIrq <= 1'b0;
      rxRelease <= 1'b0;
    end
    else
    begin
      msgCount <= resetMode ? '0 : next_msgCount;
      rxRelease <= releaseHit; // R10
      // Fresh message or next one after release re-interrupts.
      // Releasing the last message stays silent.
      rxIrq <= rxIrqEnable && !resetMode && next_msgCount != '0 &&
               (msgStored || releaseHit); // R10 R11
    end
  end

  // Error warning at ninety-six and change interrupt.
  // Both edges of either bit interrupt; the counters
  // themselves live in the frame engine.
  assign errWarn = (txErrCount >= WARN_LIMIT) ||
                   (rxErrCount >= WARN_LIMIT); // R16 R22
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      errWarnLast <= 1'b0;
      busOffLast <= 1'b0;
      errorIrq <= 1'b0;
    end
    else
    begin
      errWarnLast <= errWarn;
      busOffLast <= busOff;
      errorIrq <= (errWarn != errWarnLast) || (busOff != busOffLast); // R22
    end
  end

  // Status word assembled from live state.
  // Nothing here is writable, so host writes cannot upset it.
  always_comb
  begin
    statusWord = 8'h00;
    statusWord[ST_BUS_OFF] = busOff; // R15
    statusWord[ST_ERR_WARN] = errWarn; // R16
    statusWord[ST_TX_ACT] = (txState == CCSL_TX_BUSY); // R17
    statusWord[ST_RX_ACT] = rxActive; // R17
    statusWord[ST_TX_DONE] = txDoneFlag; // R18
    statusWord[ST_TX_FREE] = (txState == CCSL_TX_IDLE); // R19
    statusWord[ST_OVERRUN] = overrunFlag; // R20
    statusWord[ST_RX_FULL] = (msgCount != '0); // R21
  end

  // Read port; status writes fall on the floor.
  // Data stands one cycle only and returns to zero after,
  // so a stale word never looks like a fresh read.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdata <= 8'h00;
    else if (regRd)
    begin
      if (regAddr == STATUS_OFFSET)
        regRdata <= statusWord; // R15
      else if (regAddr == CMD_OFFSET)
        regRdata <= CMD_READ_VALUE;
      else
        regRdata <= UNMAPPED_READ_VALUE;
    end
    else
      regRdata <= 8'h00;
  end
endmodule // can_command_status_logic

// ===== rtl/ccsl_pkg.sv
package ccsl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_OFFSET = 8'h01;
  localparam logic [7:0] STATUS_OFFSET = 8'h02;
  localparam logic [7:0] CMD_READ_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // Command bit positions
  localparam int CMD_TX_REQ = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RELEASE = 2;
  localparam int CMD_CLR_OVR = 3;
  localparam int CMD_SLEEP = 4;
  // Status bit positions
  localparam int ST_RX_FULL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_TX_FREE = 2;
  localparam int ST_TX_DONE = 3;
  localparam int ST_RX_ACT = 4;
  localparam int ST_TX_ACT = 5;
  localparam int ST_ERR_WARN = 6;
  localparam int ST_BUS_OFF = 7;
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam int BUS_FREE_BITS = 11;
  localparam int CLOCK_OUTPUT_PIN_HOLD_BITS = 15;
  localparam logic [7:0] STATUS_RESET = 8'h0c;
  typedef enum logic [1:0] {CCSL_AWAKE, CCSL_DRAIN, CCSL_ASLEEP} ccsl_sleep_t;
  typedef enum logic [1:0] {CCSL_TX_IDLE, CCSL_TX_PEND, CCSL_TX_BUSY}
    ccsl_tx_t;
endpackage

// ===== tb/ccsl_monitor.sv
`timescale 1ns/100ps
module ccsl_monitor
  import ccsl_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWdata, // Data
  input wire logic regWr, // Write
  input wire logic regRd, // Read
  input wire logic [7:0] regRdata, // Read data
  input wire logic resetMode, // Reset mode
  input wire logic busOff, // Bus-off
  input wire logic busActive, // Bus busy
  input wire logic irqPending, // Pending irq
  input wire logic txStarted, // Frame start
  input wire logic msgLost, // Lost message
  input wire logic txGo, // Pending frame
  input wire logic txBufWriteAccept, // Accept
  input wire logic rxEnable, // Rx allowed
  input wire logic sleeping, // Asleep
  input wire logic clockOutEnable, // Clock out
  input wire logic wakeIrq, // Wake pulse
  input wire logic overrunIrq // Overrun pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Command writes decoded once
  wire cmdWr = regWr && regAddr == CMD_OFFSET;
  sequence lost_twice;
    msgLost && !cmdWr ##1 msgLost && !cmdWr;
  endsequence
  sequence bus_wake;
    sleeping && busActive;
  endsequence
  hold_req_a: assert property (
    cmdWr && !regWdata[1] && txGo && !txStarted && !resetMode |=> txGo)
    else $error("request dropped");
  abort_tx_a: assert property (
    cmdWr && regWdata[1] && txGo && !txStarted |=> !txGo)
    else $error("abort ignored");
  buf_lock_a: assert property (txGo |-> !txBufWriteAccept)
    else $error("locked buffer written");
  cmd_read_a: assert property (
    regRd && regAddr == CMD_OFFSET |=> regRdata == CMD_READ_VALUE)
    else $error("command read wrong");
  bus_off_a: assert property (
    regRd && regAddr == STATUS_OFFSET && $stable(busOff)
    |=> regRdata[7] == $past(busOff))
    else $error("bus-off bit wrong");
  ovr_once_a: assert property (lost_twice |=> !overrunIrq)
    else $error("repeat overrun irq");
  sleep_refuse_a: assert property (
    cmdWr && regWdata[4] && !resetMode && !sleeping
    && (irqPending || busActive) |=> wakeIrq)
    else $error("no wake irq");
  bus_wake_a: assert property (
    bus_wake |=> !sleeping && wakeIrq && !rxEnable)
    else $error("bad bus wake");
  clk_stop_a: assert property (!clockOutEnable |-> sleeping)
    else $error("clock stopped early");
endmodule // ccsl_monitor

// ===== tb/ccsl_host_model.sv
`timescale 1ns/100ps
module ccsl_host_model (
  input wire logic core_clk, // Clock
  input wire logic [7:0] regRdata, // Read data
  output logic [7:0] regAddr, // Address
  output logic [7:0] regWdata, // Write data
  output logic regWr, // Write strobe
  output logic regRd // Read strobe
);
  // Bus idle at time zero
  initial
  begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Idle cycle after each write lets commands settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    regWdata <= ~d; // Stale data not left on bus
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    d = regRdata;
  endtask
endmodule // ccsl_host_model

// ===== tb/can_command_status_logic_tb.sv
`timescale 1ns/100ps
module can_command_status_logic_tb;
  import ccsl_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, regWr, regRd, txGo, rxRelease;
  logic resetMode = 1'b1, busOff = 1'b0, busActive = 1'b0, bitTick = 1'b0;
  logic recessiveBit = 1'b1, irqPending = 1'b0, interruptLineLow = 1'b0;
  logic rxIrqEnable = 1'b1, txStarted = 1'b0, txDone = 1'b0, txEnded = 1'b0;
  logic rxActive = 1'b0, msgStored = 1'b0, msgLost = 1'b0, txBufWrite = 1'b1;
  logic txBufWriteAccept, rxEnable, sleeping, clockOutEnable;
  logic wakeIrq, overrunIrq, errorIrq, rxIrq;
  logic [7:0] regAddr, regWdata, regRdata, got;
  logic [7:0] txErrCount = 8'h00, rxErrCount = 8'h00;
  int bad_count = 0, total_checks = 0, cycles = 0, wakes = 0, ovrs = 0;
  int pend = 0, busy = 0, done = 1, cnt = 0, ovr = 0, w0, seed;
  int rxIrqs = 0, rels = 0, errs = 0, e0;
  can_command_status_logic i_can_command_status_logic (.*);
  ccsl_host_model i_ccsl_host_model (.*);
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  // Pulse tallies and hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    wakes <= wakes + wakeIrq;
    ovrs <= ovrs + overrunIrq;
    rxIrqs <= rxIrqs + rxIrq;
    rels <= rels + rxRelease;
    errs <= errs + errorIrq;
    if (cycles == 3000)
    begin
      bad_count = bad_count + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    i_ccsl_host_model.wr(CMD_OFFSET, d);
  endtask
  // Status read against the integer model
  task automatic stat();
    i_ccsl_host_model.rd(STATUS_OFFSET, got);
    check(got, {busOff, txErrCount >= 8'h60 || rxErrCount >= 8'h60,
      busy != 0, rxActive, done != 0, pend + busy == 0, ovr != 0, cnt != 0});
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk) bitTick <= 1'b1;
      @(posedge core_clk) bitTick <= 1'b0;
    end
  endtask
  initial
  begin
    seed = $urandom(32'h531fa687);
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    stat();
    i_ccsl_host_model.rd(CMD_OFFSET, got);
    check(got, 8'hff);
    wr(8'h10);
    @(posedge core_clk) resetMode <= 1'b0;
    ticks(16);
    check({sleeping, clockOutEnable}, 8'h01);
    wr(8'h01);
    pend = 1;
    done = 0;
    stat();
    wr(8'h00);
    stat();
    wr(8'h02);
    pend = 0;
    stat();
    wr(8'h01);
    @(posedge core_clk) txStarted <= 1'b1;
    @(posedge core_clk) txStarted <= 1'b0;
    busy = 1;
    wr(8'h02);
    stat();
    @(posedge core_clk) {txDone, txEnded} <= 2'h3;
    @(posedge core_clk) {txDone, txEnded} <= 2'h0;
    busy = 0;
    done = 1;
    stat();
    @(posedge core_clk) msgStored <= 1'b1;
    @(posedge core_clk) msgStored <= 1'b0;
    cnt = 1;
    stat();
    repeat (2) @(posedge core_clk) msgLost <= 1'b1;
    @(posedge core_clk) msgLost <= 1'b0;
    ovr = 1;
    i_ccsl_host_model.wr(STATUS_OFFSET, 8'h00);
    wr(8'h00);
    stat();
    check(8'(ovrs), 8'h01);
    wr(8'h0c);
    cnt = 0;
    ovr = 0;
    stat();
    repeat (6)
    begin
      @(posedge core_clk) txErrCount <= 8'($urandom_range(128, 64));
      rxErrCount <= 8'($urandom_range(100, 90));
      busOff <= 1'($urandom);
      rxActive <= 1'($urandom);
      stat();
    end
    @(posedge core_clk) {busOff, rxActive, txErrCount, rxErrCount} <= 18'h0;
    ticks(11);
    w0 = wakes;
    irqPending <= 1'b1;
    wr(8'h10);
    irqPending <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(8'(wakes - w0), 8'h01);
    wr(8'h10);
    ticks(14);
    @(posedge core_clk);
    check({sleeping, clockOutEnable}, 8'h01);
    ticks(1);
    @(posedge core_clk);
    check({sleeping, clockOutEnable}, 8'h02);
    @(posedge core_clk) busActive <= 1'b1;
    @(posedge core_clk) busActive <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({8'(wakes - w0), sleeping, rxEnable}, 8'h08);
    ticks(10);
    @(posedge core_clk);
    check(rxEnable, 8'h00);
    ticks(1);
    // Bus-free is seen on the last tick edge, rxEnable the edge after
    repeat (2) @(posedge core_clk);
    check(rxEnable, 8'h01);
    check(8'(rxIrqs), 8'h01);
    check(8'(rels), 8'h01);
    e0 = errs;
    @(posedge core_clk) txErrCount <= WARN_LIMIT;
    repeat (3) @(posedge core_clk);
    check(8'(errs - e0), 8'h01);
    close_out();
  end
endmodule // can_command_status_logic_tb
bind can_command_status_logic ccsl_monitor i_ccsl_monitor (.*);
